//--- pkg/flash_map_consts.svh
// Purpose: offsets, field positions, reset values and map bounds of the flash map controls
// Assumes: 16-bit processor addresses, 8-bit register data
// Notes:   definitions only
`ifndef FLASH_MAP_CONSTS_SVH
`define FLASH_MAP_CONSTS_SVH

// ============================================================
// register offsets
`define ADDR_PENDING     16'h0fd0
`define ADDR_COMMIT      16'h0fd1
`define ADDR_VIEW        16'h0fd1

// ============================================================
// key, protect codes, reset values
`define COMMIT_KEY       8'hd5
`define PROT_DISABLE     3'h2
`define PROT_ENABLE      3'h5
`define PENDING_RESET    8'h40
`define VIEW_RESET       8'h00

// ============================================================
// field positions
`define POS_PROT_HI      7
`define POS_PROT_LO      5
`define POS_BOOT         4
`define POS_WIN_HI       3
`define POS_WIN_LO       2
`define POS_ROM_HI       1
`define POS_ROM_LO       0
`define POS_VIEW_PEN     5

// ============================================================
// address map
`define FLASH_BYTES      32'd61440
`define FLASH_BASE       16'h1000
`define BOOT_TOP         16'h17ff
`define WIN_BASE_STD     16'h8000
`define WIN_BASE_HIGH    16'h9000
`define WIN_SHIFT        16'h8000

`endif

//--- pkg/flash_map_pkg.sv
// Purpose: types shared by the flash map controls
// Assumes: nothing beyond the consts header
// Notes:   window codes follow the declaration order
package flash_map_pkg;

  // ============================================================
  // window select
  typedef enum logic [1:0] {
    WIN_STD,
    WIN_DATA_LOW,
    WIN_CODE_HIGH,
    WIN_CODE_LOW
  } window_sel_t;

  // ============================================================
  // control byte layout
  typedef struct packed {
    logic [2:0]  prot;
    logic        boot;
    window_sel_t win;
    logic [1:0]  rom;
  } flash_ctrl_t;

endpackage

//--- pkg/flash_map_if.sv
// Purpose: carries committed window settings to the mapper and its answer back
// Assumes: mapper is purely combinational
// Notes:   one modport per side
`timescale 1ns/1ps
`default_nettype none

interface flash_map_if;
  import flash_map_pkg::*;

  // ============================================================
  // signals
  window_sel_t window_sel;
  logic        boot_show;
  logic [15:0] req_addr;
  logic [15:0] flash_off;
  logic        flash_hit;
  logic        boot_hit;
  logic        code_space;

  modport ctrl (
    output window_sel, boot_show, req_addr,
    input  flash_off, flash_hit, boot_hit, code_space
  );

  modport mapper (
    input  window_sel, boot_show, req_addr,
    output flash_off, flash_hit, boot_hit, code_space
  );
endinterface

`default_nettype wire

//--- design/bit_sync.sv
// Purpose: two-flop synchroniser for one level from outside the clock domain
// Assumes: input changes slowly against the clock
// Notes:   first flop is read by the second only
`timescale 1ns/1ps
`default_nettype none

module bit_sync (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_async,
  output var  logic o_sync
);

  // ============================================================
  // two stages
  logic meta_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= 1'b0;
      o_sync <= 1'b0;
    end else begin
      meta_q <= i_async;
      o_sync <= meta_q;
    end
  end

endmodule

`default_nettype wire

//--- design/flash_window_map.sv
// Purpose: translates a data-space address through the committed flash window
// Assumes: settings come from committed state and the synced mode pins
// Notes:   combinational; caller registers the answer
`timescale 1ns/1ps
`default_nettype none
`include "flash_map_consts.svh"

module flash_window_map (
  flash_map_if.mapper mif
);
  import flash_map_pkg::*;

  // ============================================================
  // window decode
  logic        above_std;
  logic        above_high;
  logic        win_hit;
  logic        shifted;
  logic [15:0] src_addr;
  logic        in_flash;

  assign above_std  = mif.req_addr >= `WIN_BASE_STD;
  assign above_high = mif.req_addr >= `WIN_BASE_HIGH;

  // low windows open at the higher base so source stays inside 1000..7fff
  assign shifted = (mif.window_sel == WIN_DATA_LOW) || (mif.window_sel == WIN_CODE_LOW);
  assign win_hit = shifted ? above_high : above_std;
  assign src_addr = (win_hit && shifted) ? (mif.req_addr - `WIN_SHIFT) : mif.req_addr;
  assign mif.code_space = win_hit &&
                          ((mif.window_sel == WIN_CODE_HIGH) || (mif.window_sel == WIN_CODE_LOW));

  // ============================================================
  // boot overlay and flash range
  assign mif.boot_hit  = mif.boot_show && (src_addr >= `FLASH_BASE) && (src_addr <= `BOOT_TOP);
  assign in_flash      = src_addr >= `FLASH_BASE;
  assign mif.flash_hit = in_flash && !mif.boot_hit;
  // offset spans the whole array: 0000..efff
  assign mif.flash_off = in_flash ? (src_addr - `FLASH_BASE) : 16'h0000;

endmodule

`default_nettype wire

//--- design/flash_map_control_regs.sv
// Purpose: shadowed flash control byte, key commit and committed-state monitor
// Assumes: register port from processor logic on the same clock; mode pins asynchronous
// Notes:   all outputs registered; answers reflect committed state, except reads of the pending register
//
// Operation
// - protect code 010 disables commands and toggle, 101 enables, others reserved
// - boot bit hides/shows boot ROM; serial mode always shows, monitor reads 1
// - window 00 standard data mapping; 01 maps data 1000-7fff at 9000-ffff
// - window 10 maps code 8000-ffff; 11 maps code 1000-7fff at 9000-ffff
// - writes land in pending register; key 0xd5 copies it to effective register
// - commit register write-only; key 0xd5 applies pending settings, others reserved
// - monitor returns effective settings, not pending ones
// - monitor: boot bit 4, window bits 3:2, rom select bits 1:0
// - monitor bit 5 is 1 only while committed protect code is 101
// - monitor bits 7 and 6 always read 0
// - committing key with protect 101 puts flash array in active state
// - controls govern processor and serial modes; parallel mode bypasses them, except rom select and flash array activity, which still follow each commit
// - managed flash array holds 61440 bytes
// - after reset protect field holds 010, commands disabled
// - disabled protection rejects new commands, leaves running sequence alone
//
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "flash_map_consts.svh"

module flash_map_control_regs (
  input  wire logic                       i_sys_clk,
  input  wire logic                       i_rst_n,
  input  wire logic [15:0]                i_addr,
  input  wire logic [7:0]                 i_wdata,
  input  wire logic                       i_wr,
  input  wire logic                       i_rd,
  output var  logic [7:0]                 o_rdata,
  input  wire logic                       i_serial_mode,
  input  wire logic                       i_parallel_mode,
  input  wire logic                       i_cmd_req,
  input  wire logic                       i_cmd_busy,
  output var  logic                       o_cmd_accept,
  output var  logic                       o_cmd_reject,
  output var  logic                       o_seq_continue,
  output var  logic                       o_cmd_enable,
  output var  logic                       o_boot_rom_show,
  output var  flash_map_pkg::window_sel_t o_window_select,
  output var  logic [1:0]                 o_rom_select,
  output var  logic                       o_flash_active,
  output var  logic                       o_regs_govern,
  input  wire logic [15:0]                i_access_addr,
  output var  logic                       o_map_flash,
  output var  logic                       o_map_boot,
  output var  logic                       o_map_code,
  output var  logic [15:0]                o_map_offset
);
  import flash_map_pkg::*;

  // ============================================================
  // mode pins
  logic serial_s;
  logic parallel_s;

  bit_sync u_sync_serial (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_serial_mode),
    .o_sync    (serial_s)
  );

  bit_sync u_sync_parallel (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_async   (i_parallel_mode),
    .o_sync    (parallel_s)
  );

  // ============================================================
  // register decode
  logic        sel_pending;
  logic        sel_commit;
  logic        wr_pending;
  logic        wr_commit;
  logic        key_ok;
  logic        commit;
  logic        rd_pending;
  logic        rd_view;

  assign sel_pending = i_addr == `ADDR_PENDING;
  assign sel_commit  = i_addr == `ADDR_COMMIT;
  assign wr_pending  = i_wr && sel_pending;
  assign wr_commit   = i_wr && sel_commit;
  assign key_ok      = i_wdata == `COMMIT_KEY;
  assign commit      = wr_commit && key_ok;
  assign rd_pending  = i_rd && sel_pending;
  // same offset as commit: reads see the monitor, writes the key
  assign rd_view     = i_rd && (i_addr == `ADDR_VIEW);

  // ============================================================
  // pending and effective registers
  flash_ctrl_t pending_q;
  flash_ctrl_t pending_d;
  flash_ctrl_t effective_q;
  flash_ctrl_t effective_d;

  // reserved protect codes are stored as written; only decode treats them
  assign pending_d   = wr_pending ? flash_ctrl_t'(i_wdata) : pending_q;
  // a commit in the same cycle as a pending write copies the old pending value
  assign effective_d = commit ? pending_q : effective_q;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pending_q   <= flash_ctrl_t'(`PENDING_RESET);
      effective_q <= flash_ctrl_t'(`PENDING_RESET);
    end else begin
      pending_q   <= pending_d;
      effective_q <= effective_d;
    end
  end

  // ============================================================
  // committed state decode
  logic govern;
  logic prot_en;
  logic boot_eff;

  assign govern   = !parallel_s;
  // only 101 enables; 010 and every reserved code keep commands off
  assign prot_en  = effective_q.prot == `PROT_ENABLE;
  assign boot_eff = serial_s || effective_q.boot;

  // ============================================================
  // monitor and read data
  logic [7:0] view_byte;
  logic [7:0] rdata_d;

  assign view_byte[7:6]                      = 2'b00;
  assign view_byte[`POS_VIEW_PEN]            = prot_en;
  assign view_byte[`POS_BOOT]                = boot_eff;
  assign view_byte[`POS_WIN_HI:`POS_WIN_LO]  = effective_q.win;
  assign view_byte[`POS_ROM_HI:`POS_ROM_LO]  = effective_q.rom;

  // unmapped reads and idle cycles answer zero
  assign rdata_d = rd_pending ? pending_q :
                   rd_view    ? view_byte : `VIEW_RESET;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= `VIEW_RESET;
    end else begin
      o_rdata <= rdata_d;
    end
  end

  // ============================================================
  // flash array activity
  logic active_d;

  // follows each commit; array idles again once a disabling code is committed
  assign active_d = commit ? (pending_q.prot == `PROT_ENABLE) : o_flash_active;

  // ============================================================
  // command gating
  logic accept_d;
  logic reject_d;

  assign accept_d = i_cmd_req && govern && prot_en;
  assign reject_d = i_cmd_req && govern && !prot_en;

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_flash_active <= 1'b0;
      o_cmd_accept   <= 1'b0;
      o_cmd_reject   <= 1'b0;
      o_seq_continue <= 1'b0;
    end else begin
      o_flash_active <= active_d;
      o_cmd_accept   <= accept_d;
      o_cmd_reject   <= reject_d;
      // a running sequence never sees protection; it is not aborted
      o_seq_continue <= i_cmd_busy;
    end
  end

  // ============================================================
  // committed settings out
  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_cmd_enable    <= 1'b0;
      o_boot_rom_show <= 1'b0;
      o_window_select <= WIN_STD;
      o_rom_select    <= 2'b00;
      o_regs_govern   <= 1'b1;
    end else begin
      o_cmd_enable    <= govern && prot_en;
      o_boot_rom_show <= govern && boot_eff;
      o_window_select <= govern ? effective_q.win : WIN_STD;
      o_rom_select    <= effective_q.rom;
      o_regs_govern   <= govern;
    end
  end

  // ============================================================
  // window translation
  flash_map_if mif ();

  // parallel mode sees plain standard mapping, no overlay
  assign mif.window_sel = govern ? effective_q.win : WIN_STD;
  assign mif.boot_show  = govern && boot_eff;
  assign mif.req_addr   = i_access_addr;

  flash_window_map u_map (
    .mif (mif.mapper)
  );

  always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_map_flash  <= 1'b0;
      o_map_boot   <= 1'b0;
      o_map_code   <= 1'b0;
      o_map_offset <= 16'h0000;
    end else begin
      o_map_flash  <= mif.flash_hit;
      o_map_boot   <= mif.boot_hit;
      o_map_code   <= mif.code_space;
      o_map_offset <= mif.flash_off;
    end
  end

endmodule

`default_nettype wire

//--- verification/flash_map_control_regs_monitor.sv
// Purpose: port-level checks of the flash map controls
// Assumes: mode pins held steady around command requests
// Notes:   bound to the top module below
`timescale 1ns/1ps
`default_nettype none
`include "flash_map_consts.svh"

module flash_map_control_regs_monitor
  import flash_map_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic [15:0] i_addr,
  input wire logic        i_rd,
  input wire logic [7:0]  o_rdata,
  input wire logic        i_serial_mode,
  input wire logic        i_cmd_req,
  input wire logic        i_cmd_busy,
  input wire logic        o_cmd_accept,
  input wire logic        o_cmd_reject,
  input wire logic        o_seq_continue,
  input wire logic        o_cmd_enable,
  input wire logic        o_boot_rom_show,
  input wire window_sel_t o_window_select,
  input wire logic        o_regs_govern,
  input wire logic        o_map_flash,
  input wire logic [15:0] o_map_offset
);
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_rst_n);

  // ============================================================
  // register port
  a_rdata_idle_zero: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data outside its slot");
  a_view_top_zero: assert property ($past(i_rd) && $past(i_addr) == `ADDR_VIEW |-> o_rdata[7:6] == 2'b00)
    else $error("monitor top bits not zero");

  // ============================================================
  // command gating; govern checked twice since mode pins are synced
  a_answer_exactly_one: assert property ($past(i_cmd_req) && $past(o_regs_govern, 2) && o_regs_govern
    |-> o_cmd_accept != o_cmd_reject)
    else $error("request not answered once");
  a_answer_needs_req: assert property (o_cmd_accept || o_cmd_reject |-> $past(i_cmd_req))
    else $error("answer without request");
  // enable and answer leave the same edge, so they share one committed state
  a_reject_disabled: assert property ($past(i_cmd_req) && !o_cmd_enable && o_regs_govern |-> o_cmd_reject)
    else $error("request not rejected while protected");
  a_seq_follows_busy: assert property (o_seq_continue == $past(i_cmd_busy))
    else $error("running sequence disturbed");

  // ============================================================
  // modes and map
  a_parallel_bypass: assert property (!o_regs_govern && $past(!o_regs_govern)
    |-> !o_cmd_enable && o_window_select == WIN_STD)
    else $error("controls active in parallel mode");
  a_serial_boot_on: assert property ((i_serial_mode && o_regs_govern) [*5] |-> o_boot_rom_show)
    else $error("boot rom hidden in serial mode");
  a_offset_in_array: assert property (o_map_flash |-> o_map_offset <= 16'hefff)
    else $error("offset beyond flash array");

  c_accept: cover property (o_cmd_accept);
  c_reject: cover property (o_cmd_reject);
  c_serial_boot: cover property (i_serial_mode && o_boot_rom_show);
endmodule

bind flash_map_control_regs flash_map_control_regs_monitor u_mon (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_rd(i_rd), .o_rdata(o_rdata),
  .i_serial_mode(i_serial_mode), .i_cmd_req(i_cmd_req), .i_cmd_busy(i_cmd_busy),
  .o_cmd_accept(o_cmd_accept), .o_cmd_reject(o_cmd_reject), .o_seq_continue(o_seq_continue),
  .o_cmd_enable(o_cmd_enable), .o_boot_rom_show(o_boot_rom_show), .o_window_select(o_window_select),
  .o_regs_govern(o_regs_govern), .o_map_flash(o_map_flash), .o_map_offset(o_map_offset)
);

`default_nettype wire

//--- verification/flash_map_control_regs_tb.sv
// Purpose: register, commit, gating and map scenarios
// Assumes: one clock, strobes one cycle long
// Notes:   mode pins settle through a two-flop sync
`timescale 1ns/1ps
`default_nettype none
`include "flash_map_consts.svh"

module flash_map_control_regs_tb;
  import flash_map_pkg::*;
  logic        sys_clk, rst_n, wr_s, rd_s, ser, par, req, busy;
  logic [15:0] addr, acc, moff;
  logic [7:0]  wdata, rdata;
  logic        accept, reject, seq, en, boot, active, govern, mflash, mboot, mcode;
  logic [1:0]  rom;
  window_sel_t win;
  int          failures = 0;
  int          checks_done = 0;

  flash_map_control_regs u_dut (
    .i_sys_clk(sys_clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
    .o_rdata(rdata), .i_serial_mode(ser), .i_parallel_mode(par), .i_cmd_req(req), .i_cmd_busy(busy),
    .o_cmd_accept(accept), .o_cmd_reject(reject), .o_seq_continue(seq), .o_cmd_enable(en),
    .o_boot_rom_show(boot), .o_window_select(win), .o_rom_select(rom), .o_flash_active(active),
    .o_regs_govern(govern), .i_access_addr(acc), .o_map_flash(mflash), .o_map_boot(mboot),
    .o_map_code(mcode), .o_map_offset(moff)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  // ============================================================
  // tasks
  task automatic final_report();
    if (failures == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge sys_clk);
    wr_s <= 1'b0;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge sys_clk);
    rd_s <= 1'b0;
    @(negedge sys_clk);
    chk(16'(rdata), 16'(exp));
  endtask

  task automatic cmd(input logic [1:0] exp);
    @(posedge sys_clk);
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    @(negedge sys_clk);
    chk(16'({accept, reject}), 16'(exp));
  endtask

  // two edges: settings lag the commit by one
  task automatic mp(input logic [15:0] a, input logic [2:0] exp, input logic [15:0] off);
    @(posedge sys_clk);
    acc <= a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk(16'({mflash, mcode, mboot}), 16'(exp));
    if (exp[2]) chk(moff, off);
  endtask

  // ============================================================
  // watchdog: about forty times the expected run
  initial begin
    #20000;
    failures++;
    final_report();
  end

  // ============================================================
  // scenarios
  initial begin
    {rst_n, wr_s, rd_s, ser, par, req, busy} = 7'h00;
    addr = 16'h0000;
    acc = 16'h0000;
    wdata = 8'h00;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`ADDR_PENDING, 8'h40);
    rd(`ADDR_VIEW, 8'h00);
    rd(16'h0fd5, 8'h00);
    cmd(2'b01);
    wr(`ADDR_PENDING, 8'hb5);
    rd(`ADDR_PENDING, 8'hb5);
    rd(`ADDR_VIEW, 8'h00);
    wr(`ADDR_COMMIT, 8'h55);
    rd(`ADDR_VIEW, 8'h00);
    wr(`ADDR_COMMIT, `COMMIT_KEY);
    rd(`ADDR_VIEW, 8'h35);
    chk(16'(active), 16'h0001);
    chk(16'({en, rom}), 16'h0005);
    cmd(2'b10);
    mp(16'h9400, 3'b001, 16'h0000);
    @(posedge sys_clk);
    busy <= 1'b1;
    for (int w = 0; w < 4; w++) begin
      wr(`ADDR_PENDING, {3'b010, 1'b0, 2'(w), 2'(w)});
      wr(`ADDR_COMMIT, `COMMIT_KEY);
      rd(`ADDR_VIEW, {4'h0, 2'(w), 2'(w)});
      chk(16'({en, rom}), 16'(w));
      chk(16'({active, seq}), 16'h0001);
      cmd(2'b01);
      mp(16'hc000, {1'b1, w[1], 1'b0}, w[0] ? 16'h3000 : 16'hb000);
      mp(16'h2000, 3'b100, 16'h1000);
    end
    @(posedge sys_clk);
    ser <= 1'b1;
    repeat (5) @(posedge sys_clk);
    rd(`ADDR_VIEW, 8'h1f);
    chk(16'(boot), 16'h0001);
    @(posedge sys_clk);
    ser <= 1'b0;
    par <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk(16'({govern, win}), 16'h0000);
    cmd(2'b00);
    // mid-run reset: both registers back to reset values
    @(posedge sys_clk);
    rst_n <= 1'b0;
    par <= 1'b0;
    busy <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    rd(`ADDR_PENDING, 8'h40);
    rd(`ADDR_VIEW, 8'h00);
    chk(16'({active, en, govern}), 16'h0001);
    final_report();
  end
endmodule

`default_nettype wire
